// File: rtl/tccp_pkg.sv
/*
 * tccp_pkg: shared constants and carrier types for the timer
 * capture/compare pair.
 * assumes: one 16-bit counter channel supplies count and mode inputs.
 */
package tccp_pkg;
    // =====================================================
    // widths and reset values
    localparam int          CNT_W      = 16;
    localparam logic [15:0] CC_RESET   = 16'h0000;
    localparam logic [15:0] CNT_ZERO   = 16'h0000;
    localparam logic [15:0] CNT_MAX    = 16'hffff;
    localparam logic [15:0] WORD_LANES = 16'hffff;

    // =====================================================
    // capture/compare control field positions
    localparam int CTL_A_CAPTURE = 0;
    localparam int CTL_A_TRIG    = 1;
    localparam int CTL_B_CAPTURE = 2;
    localparam logic [2:0] CTL_RESET = 3'h0;

    // =====================================================
    // edge codes; 2'h2 is prohibited and never triggers
    typedef enum logic [1:0] {
        TCCP_EDGE_FALL = 2'h0,
        TCCP_EDGE_RISE = 2'h1,
        TCCP_EDGE_BAD  = 2'h2,
        TCCP_EDGE_BOTH = 2'h3
    } tccp_edge_t;

    // =====================================================
    // register write port: a and b target flags, 16 lane enables, data
    typedef struct packed {
        logic        wr_a;
        logic        wr_b;
        logic [15:0] byte_en;
        logic [15:0] data;
    } tccp_wr_t;

    // edge events seen on one trigger input
    typedef struct packed {
        logic rise;
        logic fall;
    } tccp_evt_t;

    // counter state given by the counter channel
    typedef struct packed {
        logic [15:0] count;
        logic        running;
        logic        stop_evt;
    } tccp_cnt_t;

    // turns an edge code and events into a trigger pulse
    function automatic logic edge_hit(input tccp_edge_t code,
                                      input tccp_evt_t  ev);
        logic r;
        r = 1'b0;
        case (code)
            TCCP_EDGE_FALL: r = ev.fall;
            TCCP_EDGE_RISE: r = ev.rise;
            TCCP_EDGE_BOTH: r = ev.rise | ev.fall;
            default:        r = 1'b0;
        endcase
        return r;
    endfunction
endpackage

// File: rtl/tccp_edge_det.sv
/*
 * tccp_edge_det: registers one trigger input and reports its edges.
 * assumes: input already synchronous to i_ref_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module tccp_edge_det (
    input  wire logic           i_ref_clk,
    input  wire logic           i_srst,
    input  wire logic           i_pin,
    output tccp_pkg::tccp_evt_t o_evt
);
    logic prev;
    logic next_prev;

    always_comb begin
        next_prev = i_srst ? 1'b0 : i_pin;
    end

    always_ff @(posedge i_ref_clk) begin
        prev <= next_prev;
    end

    // reset gates the events and clears history to low, so a pin high just after reset shows as a rise
    assign o_evt.rise = ~i_srst & i_pin & ~prev;
    assign o_evt.fall = ~i_srst & ~i_pin & prev;
endmodule // tccp_edge_det
`default_nettype wire

// File: rtl/tccp_cc_reg.sv
/*
 * tccp_cc_reg: one 16-bit capture/compare register with its
 * compare-match pulse.
 * assumes: capture trigger already selected by the parent.
 */
`timescale 1ns/10ps
`default_nettype none
module tccp_cc_reg (
    input  wire logic                i_ref_clk,
    input  wire logic                i_srst,
    input  wire logic                i_capture_mode,
    input  wire logic                i_capture_trig,
    input  wire logic                i_wr,
    input  wire logic [15:0]         i_wdata,
    input  wire tccp_pkg::tccp_cnt_t i_cnt,
    output logic [15:0]              o_value,
    output logic                     o_match
);
    logic [15:0] next_value;
    logic        next_match;
    logic        eq_prev;
    logic        next_eq_prev;
    logic        eq_now;

    assign eq_now = (i_cnt.count == o_value);

    always_comb begin
        next_value   = o_value;
        next_eq_prev = eq_now;
        // a pulse only when equality is first reached, and only in
        // compare mode; a zero value matches on the wrap to zero
        next_match   = ~i_capture_mode & eq_now & ~eq_prev;
        if (i_capture_mode && i_capture_trig) begin
            next_value = i_cnt.count;
        end else if (i_wr) begin
            next_value = i_wdata;
        end
        if (i_srst) begin
            next_value   = tccp_pkg::CC_RESET;
            next_match   = 1'b0;
            next_eq_prev = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        o_value <= next_value;
        o_match <= next_match;
        eq_prev <= next_eq_prev;
    end
endmodule // tccp_cc_reg
`default_nettype wire

// File: rtl/tccp_top.sv
/*
 * tccp_top: capture/compare pair for one 16-bit timer channel.
 * assumes: counter, mode control and edge configuration live outside
 * and arrive as synchronous inputs; cpu writes come as 16-bit words.
 */
// Overview of operation
// - control bit 0 makes register a compare (0) or capture (1) register
// - register a compares with the counter and raises match a on equality
// - in interval timing register a holds the interval length
// - register a in capture mode loads the counter on its trigger
// - primary source for a captures on the opposite edge; both: none
// - secondary source for a captures on its own valid edge
// - control bit 2 makes register b a compare or capture register
// - register b compares with the counter and raises match b
// - register b captures on the primary valid edge, same phase
// - register a takes only 16-bit writes and resets to zero
// - register b takes only 16-bit writes and resets to zero
// - a zero register a matches when the counter wraps to zero
// - a zero register b matches when the counter wraps to zero
// - read colliding with capture of a may be undefined; store is right
// - the same collision behaviour holds for register b
// - register b may change while running only in pattern output mode
// - control bit 1 picks secondary (0) or inverted primary (1) for a
`timescale 1ns/10ps
`default_nettype none
module tccp_top (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_srst,
    input  wire tccp_pkg::tccp_cnt_t  i_cnt,
    input  wire logic                 i_primary_trigger_in,
    input  wire logic                 i_secondary_trigger_in,
    input  wire tccp_pkg::tccp_edge_t i_primary_edge_sel,
    input  wire tccp_pkg::tccp_edge_t i_secondary_edge_sel,
    input  wire logic                 i_pattern_mode,
    input  wire logic                 i_ctl_wr,
    input  wire logic [2:0]           i_ctl_wdata,
    input  wire tccp_pkg::tccp_wr_t   i_wr,
    output logic [2:0]                o_capcmp_control,
    output logic [15:0]               o_capture_compare_a,
    output logic [15:0]               o_capture_compare_b,
    output logic                      o_match_a_irq,
    output logic                      o_match_b_irq,
    output logic                      o_wr_refused
);
    // =====================================================
    // control register
    logic [2:0] next_ctl;
    logic       next_refused;
    logic       full_word;
    logic       wr_a_ok;
    logic       wr_b_ok;

    assign full_word = (i_wr.byte_en == tccp_pkg::WORD_LANES);
    // while counting a write to a is dropped
    assign wr_a_ok = i_wr.wr_a & full_word & ~i_cnt.running;
    // b may change while counting only in pattern output mode
    assign wr_b_ok = i_wr.wr_b & full_word
                   & (~i_cnt.running | i_pattern_mode);

    always_comb begin
        next_ctl     = i_ctl_wr ? i_ctl_wdata : o_capcmp_control;
        next_refused = (i_wr.wr_a & ~wr_a_ok) | (i_wr.wr_b & ~wr_b_ok);
        if (i_srst) begin
            next_ctl     = tccp_pkg::CTL_RESET;
            next_refused = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        o_capcmp_control <= next_ctl;
        o_wr_refused     <= next_refused;
    end

    // =====================================================
    // trigger edges
    tccp_pkg::tccp_evt_t pri_evt;
    tccp_pkg::tccp_evt_t sec_evt;
    tccp_pkg::tccp_evt_t pri_inv;

    tccp_edge_det u_pri (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_pin     (i_primary_trigger_in),
        .o_evt     (pri_evt)
    );
    tccp_edge_det u_sec (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_pin     (i_secondary_trigger_in),
        .o_evt     (sec_evt)
    );

    // swapping rise and fall gives the inverse phase of the valid edge
    assign pri_inv.rise = pri_evt.fall;
    assign pri_inv.fall = pri_evt.rise;

    logic trig_a;
    logic trig_b;
    logic a_cap;
    logic b_cap;

    assign a_cap = o_capcmp_control[tccp_pkg::CTL_A_CAPTURE];
    assign b_cap = o_capcmp_control[tccp_pkg::CTL_B_CAPTURE];

    always_comb begin
        trig_a = 1'b0;
        if (o_capcmp_control[tccp_pkg::CTL_A_TRIG]) begin
            // both-edges setting yields no capture here
            if (i_primary_edge_sel != tccp_pkg::TCCP_EDGE_BOTH) begin
                trig_a = tccp_pkg::edge_hit(i_primary_edge_sel,
                                            pri_inv);
            end
        end else begin
            trig_a = tccp_pkg::edge_hit(i_secondary_edge_sel,
                                        sec_evt);
        end
        trig_b = tccp_pkg::edge_hit(i_primary_edge_sel, pri_evt);
    end

    // =====================================================
    // the two registers
    // capture wins over a write in the same cycle, so the
    // stored value is always the captured count
    tccp_cc_reg u_reg_a (
        .i_ref_clk      (i_ref_clk),
        .i_srst         (i_srst),
        .i_capture_mode (a_cap),
        .i_capture_trig (trig_a),
        .i_wr           (wr_a_ok),
        .i_wdata        (i_wr.data),
        .i_cnt          (i_cnt),
        .o_value        (o_capture_compare_a),
        .o_match        (o_match_a_irq)
    );
    tccp_cc_reg u_reg_b (
        .i_ref_clk      (i_ref_clk),
        .i_srst         (i_srst),
        .i_capture_mode (b_cap),
        .i_capture_trig (trig_b),
        .i_wr           (wr_b_ok),
        .i_wdata        (i_wr.data),
        .i_cnt          (i_cnt),
        .o_value        (o_capture_compare_b),
        .o_match        (o_match_b_irq)
    );

    // =====================================================
    // checks
    property p_match_a;
        @(posedge i_ref_clk) disable iff (i_srst)
        (!a_cap && i_cnt.count == o_capture_compare_a
         && !$past(i_cnt.count == o_capture_compare_a) && !$past(i_srst))
        |=> o_match_a_irq;
    endproperty
    a_match_a: assert property (p_match_a)
        else $error("match a missed");

    property p_match_b_pulse;
        @(posedge i_ref_clk) disable iff (i_srst)
        o_match_b_irq |=> !o_match_b_irq;
    endproperty
    a_match_b_pulse: assert property (p_match_b_pulse)
        else $error("match b longer than one cycle");

    property p_no_match_cap;
        @(posedge i_ref_clk) disable iff (i_srst)
        $past(a_cap) |-> !o_match_a_irq;
    endproperty
    a_no_match_cap: assert property (p_no_match_cap)
        else $error("match a in capture mode");

    property p_cap_a;
        @(posedge i_ref_clk) disable iff (i_srst)
        (a_cap && trig_a) |=> o_capture_compare_a == $past(i_cnt.count);
    endproperty
    a_cap_a: assert property (p_cap_a)
        else $error("capture a wrong");

    property p_cap_b;
        @(posedge i_ref_clk) disable iff (i_srst)
        (b_cap && trig_b) |=> o_capture_compare_b == $past(i_cnt.count);
    endproperty
    a_cap_b: assert property (p_cap_b)
        else $error("capture b wrong");

    property p_a_both_none;
        @(posedge i_ref_clk) disable iff (i_srst)
        (o_capcmp_control[tccp_pkg::CTL_A_TRIG]
         && i_primary_edge_sel == tccp_pkg::TCCP_EDGE_BOTH) |-> !trig_a;
    endproperty
    a_a_both_none: assert property (p_a_both_none)
        else $error("capture a on both-edge setting");

    sequence s_run_write_a;
        i_wr.wr_a && i_cnt.running;
    endsequence
    property p_hold_a;
        @(posedge i_ref_clk) disable iff (i_srst)
        (s_run_write_a and !(a_cap && trig_a))
        |=> $stable(o_capture_compare_a) ##0 o_wr_refused;
    endproperty
    a_hold_a: assert property (p_hold_a)
        else $error("register a written while running");

    property p_part_b;
        @(posedge i_ref_clk) disable iff (i_srst)
        (i_wr.wr_b && i_wr.byte_en != tccp_pkg::WORD_LANES
         && !(b_cap && trig_b)) |=> $stable(o_capture_compare_b);
    endproperty
    a_part_b: assert property (p_part_b)
        else $error("partial write reached register b");

    property p_reset;
        @(posedge i_ref_clk)
        i_srst |=> o_capture_compare_a == tccp_pkg::CC_RESET
                   && o_capture_compare_b == tccp_pkg::CC_RESET;
    endproperty
    a_reset: assert property (p_reset)
        else $error("registers not cleared by reset");

    property p_match_b;
        @(posedge i_ref_clk) disable iff (i_srst)
        (!b_cap && i_cnt.count == o_capture_compare_b
         && !$past(i_cnt.count == o_capture_compare_b) && !$past(i_srst))
        |=> o_match_b_irq;
    endproperty
    a_match_b: assert property (p_match_b)
        else $error("match b missed");

    sequence s_wrap;
        (i_cnt.count == tccp_pkg::CNT_MAX)
        ##1 (i_cnt.count == tccp_pkg::CNT_ZERO && !$past(i_srst));
    endsequence
    property p_wrap_a;
        @(posedge i_ref_clk) disable iff (i_srst)
        (s_wrap ##0 (!a_cap && o_capture_compare_a == tccp_pkg::CNT_ZERO
                     && $stable(o_capture_compare_a))) |=> o_match_a_irq;
    endproperty
    a_wrap_a: assert property (p_wrap_a)
        else $error("zero register a missed the wrap");

    // reset clears edge history, so the cycle after it is left out
    sequence s_pri_rise;
        !i_primary_trigger_in ##1 i_primary_trigger_in;
    endsequence
    sequence s_pri_fall;
        i_primary_trigger_in ##1 !i_primary_trigger_in;
    endsequence
    sequence s_sec_rise;
        !i_secondary_trigger_in ##1 i_secondary_trigger_in;
    endsequence

    property p_inv_a_rise;
        @(posedge i_ref_clk) disable iff (i_srst)
        (s_pri_rise ##0 (a_cap && o_capcmp_control[tccp_pkg::CTL_A_TRIG]
         && i_primary_edge_sel == tccp_pkg::TCCP_EDGE_FALL && !$past(i_srst)))
        |=> o_capture_compare_a == $past(i_cnt.count);
    endproperty
    a_inv_a_rise: assert property (p_inv_a_rise)
        else $error("capture a missed the rising pin");

    property p_sec_a;
        @(posedge i_ref_clk) disable iff (i_srst)
        (s_sec_rise ##0 (a_cap && !o_capcmp_control[tccp_pkg::CTL_A_TRIG]
         && (i_secondary_edge_sel == tccp_pkg::TCCP_EDGE_RISE
             || i_secondary_edge_sel == tccp_pkg::TCCP_EDGE_BOTH)
         && !$past(i_srst)))
        |=> o_capture_compare_a == $past(i_cnt.count);
    endproperty
    a_sec_a: assert property (p_sec_a)
        else $error("capture a missed the secondary edge");

    property p_same_b;
        @(posedge i_ref_clk) disable iff (i_srst)
        (s_pri_fall ##0 (b_cap
         && (i_primary_edge_sel == tccp_pkg::TCCP_EDGE_FALL
             || i_primary_edge_sel == tccp_pkg::TCCP_EDGE_BOTH)
         && !$past(i_srst)))
        |=> o_capture_compare_b == $past(i_cnt.count);
    endproperty
    a_same_b: assert property (p_same_b)
        else $error("capture b missed the falling pin");

    property p_bad_a;
        @(posedge i_ref_clk) disable iff (i_srst)
        (a_cap && !o_capcmp_control[tccp_pkg::CTL_A_TRIG] && !i_wr.wr_a
         && i_secondary_edge_sel == tccp_pkg::TCCP_EDGE_BAD)
        |=> $stable(o_capture_compare_a);
    endproperty
    a_bad_a: assert property (p_bad_a)
        else $error("capture a on a prohibited edge code");

    property p_write_a;
        @(posedge i_ref_clk) disable iff (i_srst)
        (i_wr.wr_a && !i_wr.wr_b && i_wr.byte_en == tccp_pkg::WORD_LANES
         && !i_cnt.running && !a_cap)
        |=> o_capture_compare_a == $past(i_wr.data) && !o_wr_refused;
    endproperty
    a_write_a: assert property (p_write_a)
        else $error("full write to stopped register a lost");

    property p_run_b;
        @(posedge i_ref_clk) disable iff (i_srst)
        (i_wr.wr_b && i_cnt.running && !i_pattern_mode
         && !(b_cap && trig_b)) |=> $stable(o_capture_compare_b) ##0 o_wr_refused;
    endproperty
    a_run_b: assert property (p_run_b)
        else $error("register b written while running");

    property p_pattern_b;
        @(posedge i_ref_clk) disable iff (i_srst)
        (i_wr.wr_b && i_wr.byte_en == tccp_pkg::WORD_LANES
         && i_cnt.running && i_pattern_mode && !b_cap)
        |=> o_capture_compare_b == $past(i_wr.data);
    endproperty
    a_pattern_b: assert property (p_pattern_b)
        else $error("pattern mode write to register b lost");
endmodule // tccp_top
`default_nettype wire

// File: tb/tccp_cnt_model.sv
/*
 * tccp_cnt_model: counter channel seen by the capture/compare pair.
 * assumes: bench drives run and load just after rising edges.
 */
`timescale 1ns/10ps
`default_nettype none
module tccp_cnt_model (
    input  wire logic           i_ref_clk,
    input  wire logic           i_srst,
    input  wire logic           i_run,
    input  wire logic           i_load,
    input  wire logic [15:0]    i_load_val,
    output tccp_pkg::tccp_cnt_t o_cnt
);
    // =========================================
    // count state
    logic [15:0] count;
    logic [15:0] next_count;
    logic        run_q;
    always_comb begin
        next_count = count;
        if (i_load)
            next_count = i_load_val;
        else if (i_run)
            next_count = count + 16'h0001;
    end
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            count <= 16'h0000;
            run_q <= 1'b0;
        end else begin
            count <= next_count;
            run_q <= i_run;
        end
    end
    // stops are reported for the one cycle after run falls; captures do not gate them
    assign o_cnt = '{count: count, running: i_run,
                     stop_evt: run_q & ~i_run};
endmodule // tccp_cnt_model
`default_nettype wire

// File: tb/test_timer_capture_compare_pair.sv
/*
 * test_timer_capture_compare_pair: queue-checked bench for tccp_top.
 * assumes: tccp_cnt_model stands for the counter; pins are synchronous.
 */
`timescale 1ns/10ps
`default_nettype none
module test_timer_capture_compare_pair;
    // =========================================
    // signals
    logic                clk, srst, pri, sec, pat, ctl_wr, run, load;
    logic                ref_p, ma, mb;
    logic [2:0]          ctl_wd, ctl, ce;
    logic [15:0]         load_val, ra, rb, la, lb, lc, pc, va, vb;
    logic [15:0]         qa[$], qb[$], qma[$], qmb[$], qr[$], qc[$];
    tccp_pkg::tccp_edge_t pes, ses;
    tccp_pkg::tccp_wr_t  wr;
    tccp_pkg::tccp_cnt_t cnt;
    integer              seed = 32'h49447f94;
    int                  error_cnt = 0;
    int                  tests_run = 0;

    tccp_cnt_model cnt_u (.i_ref_clk(clk), .i_srst(srst), .i_run(run),
        .i_load(load), .i_load_val(load_val), .o_cnt(cnt));
    tccp_top dut_u (.i_ref_clk(clk), .i_srst(srst), .i_cnt(cnt),
        .i_primary_trigger_in(pri), .i_secondary_trigger_in(sec),
        .i_primary_edge_sel(pes), .i_secondary_edge_sel(ses),
        .i_pattern_mode(pat), .i_ctl_wr(ctl_wr), .i_ctl_wdata(ctl_wd),
        .i_wr(wr), .o_capcmp_control(ctl), .o_capture_compare_a(ra),
        .o_capture_compare_b(rb), .o_match_a_irq(ma),
        .o_match_b_irq(mb), .o_wr_refused(ref_p));

    // =========================================
    // checking and closing
    task automatic chk(input string nm, input logic [15:0] e, g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic take(input string nm, ref logic [15:0] q[$],
                        input logic [15:0] g);
        if (q.size() == 0) begin
            error_cnt++;
            $display("unexpected %s: expected none seen %h", nm, g);
        end else
            chk(nm, q.pop_front(), g);
    endtask
    task automatic wrap_up;
        if (error_cnt == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // =========================================
    // drivers
    task automatic wreg(input logic b, input logic [15:0] be, d);
        @(posedge clk);
        wr <= '{wr_a: !b, wr_b: b, byte_en: be, data: d};
        @(posedge clk);
        wr.wr_a <= 1'b0;
        wr.wr_b <= 1'b0;
    endtask
    task automatic runc(input logic v);
        @(posedge clk);
        run <= v;
    endtask
    task automatic loadc(input logic [15:0] v);
        @(posedge clk);
        load <= 1'b1;
        load_val <= v;
        @(posedge clk);
        load <= 1'b0;
    endtask
    task automatic wctl(input logic [2:0] v);
        if (v !== ce)
            qc.push_back({13'h0, v});
        ce = v;
        @(posedge clk);
        ctl_wr <= 1'b1;
        ctl_wd <= v;
        @(posedge clk);
        ctl_wr <= 1'b0;
    endtask
    function automatic logic hit(input logic [1:0] c, input logic r);
        return c == 2'h3 || (c == 2'h1 && r) || (c == 2'h0 && !r);
    endfunction
    // expected capture is the count of the cycle in which the pin changes
    task automatic tog(input logic p, v, ha, hb);
        @(posedge clk);
        if (p)
            pri <= v;
        else
            sec <= v;
        #1;
        if (ha)
            qa.push_back(cnt.count);
        if (hb)
            qb.push_back(cnt.count);
        repeat (4) @(posedge clk); // level held over four count clocks
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // =========================================
    // main sequence
    initial begin
        srst = 1'b1;
        pri = 1'b0;
        sec = 1'b0;
        pat = 1'b0;
        ctl_wr = 1'b0;
        ctl_wd = 3'h0;
        ce = 3'h0;
        run = 1'b0;
        load = 1'b0;
        load_val = 16'h0000;
        pes = tccp_pkg::TCCP_EDGE_FALL;
        ses = tccp_pkg::TCCP_EDGE_FALL;
        wr = '0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        loadc(16'h0100);
        va = 16'h8000 | 16'($random(seed));
        vb = 16'h8000 | 16'($random(seed));
        qa.push_back(va);
        qb.push_back(vb);
        qr.push_back(16'h0001);
        qr.push_back(16'h0001);
        wreg(1'b0, 16'hffff, va);
        wreg(1'b1, 16'hffff, vb);
        wreg(1'b0, 16'h00ff, ~va);
        wreg(1'b1, 16'hff00, ~vb);
        va = 16'h0103 + 16'($random(seed) & 15);
        vb = 16'h0103 + 16'($random(seed) & 15);
        qa.push_back(va);
        qb.push_back(vb);
        qma.push_back(va);
        qmb.push_back(vb);
        wreg(1'b0, 16'hffff, va);
        wreg(1'b1, 16'hffff, vb);
        runc(1'b1);
        // pins wander while both are compare registers: nothing may load
        repeat (8) begin
            pri <= 1'($random(seed));
            sec <= 1'($random(seed));
            repeat (3) @(posedge clk);
        end
        pat <= 1'($random(seed));
        qr.push_back(16'h0001);
        wreg(1'b0, 16'hffff, 16'h7000);
        pri <= 1'b0;
        sec <= 1'b0;
        pat <= 1'b1;
        qb.push_back(16'hc000);
        wreg(1'b1, 16'hffff, 16'hc000);
        pat <= 1'b0;
        qr.push_back(16'h0001);
        wreg(1'b1, 16'hffff, 16'hd000);
        runc(1'b0);
        // zero is legal here: the counter runs free, no clear on match
        qa.push_back(16'h0000);
        qb.push_back(16'h0000);
        qma.push_back(16'h0000);
        qmb.push_back(16'h0000);
        wreg(1'b0, 16'hffff, 16'h0000);
        wreg(1'b1, 16'hffff, 16'h0000);
        loadc(16'hfff0);
        runc(1'b1);
        repeat (24) @(posedge clk);
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 4; c++) begin
                runc(1'b0);
                wctl({1'b1, p[0], 1'b1});
                pes <= tccp_pkg::tccp_edge_t'(c[1:0]);
                ses <= tccp_pkg::tccp_edge_t'(c[1:0]);
                loadc(16'h4000 + 16'(p * 256 + c * 64));
                runc(1'b1);
                tog(1'b0, 1'b1, !p[0] && hit(c[1:0], 1'b1), 1'b0);
                tog(1'b0, 1'b0, !p[0] && hit(c[1:0], 1'b0), 1'b0);
                tog(1'b1, 1'b1, p[0] && c != 3 && hit(c[1:0], 1'b0),
                    hit(c[1:0], 1'b1));
                tog(1'b1, 1'b0, p[0] && c != 3 && hit(c[1:0], 1'b1),
                    hit(c[1:0], 1'b0));
            end
        end
        repeat (6) @(posedge clk);
        chk("pending", 16'h0000, 16'(qa.size() + qb.size() + qma.size()
            + qmb.size() + qr.size() + qc.size()));
        wrap_up();
    end

    // =========================================
    // result watcher: last values start at the reset values
    initial begin
        la = 16'h0000;
        lb = 16'h0000;
        lc = 16'h0000;
        pc = 16'h0000;
        wait (srst === 1'b0);
        forever begin
            @(negedge clk);
            if (ra !== la)
                take("reg_a", qa, ra);
            if (rb !== lb)
                take("reg_b", qb, rb);
            if ({13'h0, ctl} !== lc)
                take("control", qc, {13'h0, ctl});
            if (ma !== 1'b0)
                take("match_a", qma, pc);
            if (mb !== 1'b0)
                take("match_b", qmb, pc);
            if (ref_p !== 1'b0)
                take("refused", qr, 16'h0001);
            la = ra;
            lb = rb;
            lc = {13'h0, ctl};
            pc = cnt.count;
        end
    end

    // some thirteen times the expected run length
    initial begin
        #(50 * 4000);
        error_cnt++;
        wrap_up();
    end
endmodule // test_timer_capture_compare_pair
`default_nettype wire
